// ===== core/hls_pkg.sv
/*
 package for the head load sequencer: register map, field positions,
 reset values, timing counts and the pin bundles.
 assumes a 40 MHz core clock and a 32-bit axi4-lite register bus.
*/
package hls_pkg;
	localparam int unsigned CLK_HZ        = 40_000_000;
	localparam int unsigned POLL_TIME_MS  = 30;
	localparam int unsigned POLL_CYCLES   = POLL_TIME_MS * (CLK_HZ / 1000);
	localparam int unsigned DECEL_TIME_US = 100;
	localparam int unsigned DECEL_CYCLES  = DECEL_TIME_US * (CLK_HZ / 1_000_000);
	localparam int unsigned COAST_PULSES  = 100;
	localparam int unsigned CAL_ATTEMPTS  = 2;
	localparam int unsigned HOST_CLR_MAX  = 5;
	localparam int unsigned TMR_W         = 24;

	localparam logic [7:0] ADDR_CTRL    = 8'h00;
	localparam logic [7:0] ADDR_STATUS  = 8'h04;
	localparam logic [7:0] ADDR_TIMEOUT = 8'h08;
	localparam logic [7:0] ADDR_CALIB   = 8'h0c;
	localparam logic [7:0] ADDR_DEMAND  = 8'h10;

	localparam int unsigned CTRL_FCLR_BIT = 0;
	localparam int unsigned CTRL_INIT_BIT = 1;
	localparam logic [TMR_W-1:0] TIMEOUT_RST = 24'h3d0900;

	localparam logic [2:0]  SPIN_SPEED_OK  = 3'h4;
	localparam logic [11:0] DEMAND_ZERO    = 12'h000;
	localparam logic [11:0] DEMAND_ACCEL   = 12'h400;
	localparam logic [11:0] DEMAND_DECEL   = 12'hc00;
	localparam logic [11:0] DEMAND_RETRACT = 12'h300;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef struct packed {
		logic       startCond;
		logic [2:0] spinStatus;
		logic       demodActive;
		logic       cylPulse;
		logic       supplyLow;
		logic       panelClear;
		logic       seekDone;
		logic       calError;
		logic       onCylLimits;
		logic [7:0] peakLevel;
	} hls_pins_type;

	typedef struct packed {
		logic spindleRun;
		logic ampEnable;
		logic emergencyPark;
		logic actuatorLock;
		logic servoClear;
	} hls_ctl_type;

	typedef struct packed {
		logic statusRequest;
		logic loadCmd;
		logic homeTrackSeek;
		logic calSeekGo;
	} hls_cmd_type;
endpackage

// ===== core/hls_timeout.sv
/*
 loadable timeout counter with a terminal count given at run time.
 assumes load and run come from logic on the same clock.
*/
`timescale 1ns/1ps
module hls_timeout #(
	parameter int unsigned W = 24
) (
	input  wire logic         core_clk,
	input  wire logic         rst,
	input  wire logic         run,
	input  wire logic         load,
	input  wire logic [W-1:0] terminal,
	output logic              expired
);
	logic [W-1:0] cnt_ff;

	assign expired = run && (cnt_ff == terminal);

	always_ff @(posedge core_clk) begin
		if (rst || load || !run)
			cnt_ff <= '0;
		else if (cnt_ff != terminal)
			cnt_ff <= cnt_ff + 1'b1;
	end
endmodule // hls_timeout

// ===== core/hls_sequencer.sv
/*
 head load sequencer: spindle start, speed polling, load seek, home track
 seek, calibration, fault handling and emergency park gating, with an
 axi4-lite register slave.
 assumes pins are asynchronous to core_clk and the bus master is on core_clk.
*/
`timescale 1ns/1ps
module hls_sequencer
	import hls_pkg::*;
#(
	parameter int unsigned POLL_CNT = POLL_CYCLES
) (
	input  wire logic                core_clk,
	input  wire logic                rst,
	input  wire hls_pkg::hls_pins_type pins,
	output hls_pkg::hls_ctl_type     ctl,
	output hls_pkg::hls_cmd_type     cmd,
	output logic [1:0]               calKind,
	output logic [11:0]              driveDemand,
	output logic [7:0]               agcLevel,
	output logic [15:0]              forceConst,
	output logic                     inwardChanEn,
	output logic                     outwardChanEn,
	output logic                     initialSeekFault,
	output logic                     trackSettled,
	output logic                     seekComplete,
	output logic                     driveAvailable,
	input  wire logic [7:0]          s_axi_awaddr,
	input  wire logic                s_axi_awvalid,
	output logic                     s_axi_awready,
	input  wire logic [31:0]         s_axi_wdata,
	input  wire logic [3:0]          s_axi_wstrb,
	input  wire logic                s_axi_wvalid,
	output logic                     s_axi_wready,
	output logic [1:0]               s_axi_bresp,
	output logic                     s_axi_bvalid,
	input  wire logic                s_axi_bready,
	input  wire logic [7:0]          s_axi_araddr,
	input  wire logic                s_axi_arvalid,
	output logic                     s_axi_arready,
	output logic [31:0]              s_axi_rdata,
	output logic [1:0]               s_axi_rresp,
	output logic                     s_axi_rvalid,
	input  wire logic                s_axi_rready
);
	import hls_pkg::*;

	typedef enum logic [3:0] {
		ST_IDLE, ST_SPIN, ST_LCHK, ST_ACCEL, ST_COAST, ST_DECEL,
		ST_HOME, ST_CAL, ST_READY, ST_RETRACT, ST_FAULT, ST_EPARK
	} hls_state_type;

	localparam logic [6:0]  COAST_LAST = 7'(COAST_PULSES - 1);
	localparam logic [15:0] DECEL_LAST = 16'(DECEL_CYCLES - 1);
	localparam logic [1:0]  CAL_LAST   = 2'(CAL_ATTEMPTS - 1);
	localparam logic [2:0]  HCLR_MAX   = 3'(HOST_CLR_MAX);

	// two-stage synchroniser; only stage two is read
	hls_pins_type pinS1_ff, pinS2_ff, p;
	logic         cylPrev_ff, doneePrev_ff, panelPrev_ff;

	hls_state_type state_ff, nxt_state;
	hls_ctl_type   ctl_ff, nxt_ctl;
	hls_cmd_type   cmd_ff, nxt_cmd;
	logic [1:0]    calPhase_ff, nxt_calPhase;
	logic [1:0]    calTry_ff, nxt_calTry;
	logic [6:0]    pulseCnt_ff, nxt_pulseCnt;
	logic [15:0]   decelCnt_ff, nxt_decelCnt;
	logic [2:0]    hostClr_ff, nxt_hostClr;
	logic [11:0]   demand_ff, nxt_demandVal;
	logic          demandStrobe;
	logic          faultPend_ff, nxt_faultPend;
	logic          fault_ff, nxt_fault;
	logic          settled_ff, nxt_settled;
	logic          avail_ff, nxt_avail;
	logic          posErr_ff, nxt_posErr;
	logic [7:0]    agc_ff;
	logic [15:0]   force_ff, tpt_ff;
	logic          initDone_ff;
	logic [TMR_W-1:0] timeout_ff;

	logic          wdLoad, wdExp, pollExp;
	logic          cylRise, doneRise, panelRise;
	logic          speedOk, hostClrOk, contSeek;
	wire           wdRun   = state_ff inside {ST_ACCEL, ST_COAST, ST_DECEL, ST_HOME, ST_CAL, ST_RETRACT};
	wire           pollRun = state_ff inside {ST_SPIN, ST_READY};

	assign p = pinS2_ff;
	assign cylRise   = p.cylPulse && !cylPrev_ff;
	assign doneRise  = p.seekDone && !doneePrev_ff;
	assign panelRise = p.panelClear && !panelPrev_ff;
	assign speedOk   = (p.spinStatus == SPIN_SPEED_OK);
	assign contSeek  = (state_ff == ST_CAL) && calPhase_ff[1];

	always_ff @(posedge core_clk) begin
		pinS1_ff     <= pins;
		pinS2_ff     <= pinS1_ff;
		cylPrev_ff   <= pinS2_ff.cylPulse;
		doneePrev_ff <= pinS2_ff.seekDone;
		panelPrev_ff <= pinS2_ff.panelClear;
	end

	hls_timeout #(.W(TMR_W)) u_watchdog (
		.core_clk (core_clk),
		.rst      (rst),
		.run      (wdRun),
		.load     (wdLoad),
		.terminal (timeout_ff),
		.expired  (wdExp)
	);

	hls_timeout #(.W(TMR_W)) u_poll (
		.core_clk (core_clk),
		.rst      (rst),
		.run      (pollRun),
		.load     (pollExp),
		.terminal (TMR_W'(POLL_CNT - 1)),
		.expired  (pollExp)
	);

	// axi4-lite slave: address and data taken in either order
	logic       awHeld_ff, wHeld_ff, bvalid_ff, rvalid_ff;
	logic [7:0] awAddr_ff;
	logic [31:0] wData_ff, rdata_ff;
	logic [3:0] wStrb_ff;
	logic [1:0] bresp_ff, rresp_ff;
	wire        doWrite  = awHeld_ff && wHeld_ff && !bvalid_ff;
	wire        doRead   = s_axi_arvalid && s_axi_arready;
	wire        wrCtrl   = doWrite && (awAddr_ff == ADDR_CTRL) && wStrb_ff[0];
	wire        wrTmo    = doWrite && (awAddr_ff == ADDR_TIMEOUT);
	wire        wrMapped = awAddr_ff inside {ADDR_CTRL, ADDR_STATUS, ADDR_TIMEOUT, ADDR_CALIB, ADDR_DEMAND};
	wire        hostClr  = wrCtrl && wData_ff[CTRL_FCLR_BIT];
	wire [31:0] statusWord = {20'h0, ctl_ff.spindleRun, calTry_ff, hostClr_ff,
	                          ctl_ff.emergencyPark, posErr_ff, avail_ff, settled_ff, settled_ff, fault_ff};
	wire [31:0] rdMux =
		(s_axi_araddr == ADDR_CTRL)    ? {30'h0, initDone_ff, 1'b0} :
		(s_axi_araddr == ADDR_STATUS)  ? statusWord :
		(s_axi_araddr == ADDR_TIMEOUT) ? {8'h0, timeout_ff} :
		(s_axi_araddr == ADDR_CALIB)   ? {8'h0, force_ff, agc_ff} :
		(s_axi_araddr == ADDR_DEMAND)  ? {20'h0, demand_ff} : 32'h0;
	wire        rdMapped = s_axi_araddr inside {ADDR_CTRL, ADDR_STATUS, ADDR_TIMEOUT, ADDR_CALIB, ADDR_DEMAND};

	assign s_axi_awready = !awHeld_ff && !bvalid_ff;
	assign s_axi_wready  = !wHeld_ff && !bvalid_ff;
	assign s_axi_bvalid  = bvalid_ff;
	assign s_axi_bresp   = bresp_ff;
	assign s_axi_arready = !rvalid_ff;
	assign s_axi_rvalid  = rvalid_ff;
	assign s_axi_rdata   = rdata_ff;
	assign s_axi_rresp   = rresp_ff;

	always_ff @(posedge core_clk) begin
		if (rst) begin
			awHeld_ff <= 1'b0;
			wHeld_ff  <= 1'b0;
			bvalid_ff <= 1'b0;
			awAddr_ff <= 8'h00;
			wData_ff  <= 32'h0;
			wStrb_ff  <= 4'h0;
			bresp_ff  <= RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				awHeld_ff <= 1'b1;
				awAddr_ff <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				wHeld_ff <= 1'b1;
				wData_ff <= s_axi_wdata;
				wStrb_ff <= s_axi_wstrb;
			end
			if (doWrite) begin
				awHeld_ff <= 1'b0;
				wHeld_ff  <= 1'b0;
				bvalid_ff <= 1'b1;
				bresp_ff  <= wrMapped ? RESP_OKAY : RESP_SLVERR;
			end else if (bvalid_ff && s_axi_bready)
				bvalid_ff <= 1'b0;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			rvalid_ff <= 1'b0;
			rdata_ff  <= 32'h0;
			rresp_ff  <= RESP_OKAY;
		end else if (doRead) begin
			rvalid_ff <= 1'b1;
			rdata_ff  <= rdMux;
			rresp_ff  <= rdMapped ? RESP_OKAY : RESP_SLVERR;
		end else if (rvalid_ff && s_axi_rready)
			rvalid_ff <= 1'b0;
	end

	// software-written setup: init-done gate and the supervision terminal count
	always_ff @(posedge core_clk) begin
		if (rst) begin
			initDone_ff <= 1'b0;
			timeout_ff  <= TIMEOUT_RST;
		end else begin
			if (wrCtrl)
				initDone_ff <= wData_ff[CTRL_INIT_BIT];
			for (int i = 0; i < 3; i++)
				if (wrTmo && wStrb_ff[i])
					timeout_ff[i*8 +: 8] <= wData_ff[i*8 +: 8];
		end
	end

	assign hostClrOk = hostClr && (hostClr_ff < HCLR_MAX);

	always_comb begin
		nxt_state     = state_ff;
		nxt_ctl       = ctl_ff;
		nxt_cmd       = '0;
		nxt_calPhase  = calPhase_ff;
		nxt_calTry    = calTry_ff;
		nxt_pulseCnt  = pulseCnt_ff;
		nxt_decelCnt  = decelCnt_ff;
		nxt_hostClr   = hostClr_ff;
		nxt_demandVal = demand_ff;
		demandStrobe  = 1'b0;
		nxt_faultPend = faultPend_ff;
		nxt_fault     = fault_ff;
		nxt_settled   = settled_ff;
		nxt_avail     = avail_ff;
		nxt_posErr    = posErr_ff;
		wdLoad        = 1'b0;
		nxt_cmd.statusRequest = pollExp;
		case (state_ff)
			ST_IDLE: if (initDone_ff && p.startCond) begin
				nxt_ctl.spindleRun = 1'b1;
				nxt_state = ST_SPIN;
			end
			ST_SPIN: if (!p.startCond) begin
				nxt_ctl.spindleRun = 1'b0;
				nxt_state = ST_IDLE;
			end else if (pollExp && speedOk) begin
				nxt_ctl.ampEnable    = 1'b1;
				nxt_ctl.actuatorLock = 1'b0;
				nxt_ctl.servoClear   = 1'b0;
				nxt_cmd.loadCmd      = 1'b1;
				nxt_state = ST_LCHK;
			end
			ST_LCHK: if (p.demodActive) begin
				nxt_faultPend = 1'b1;
				nxt_state = ST_RETRACT;
			end else begin
				nxt_demandVal = DEMAND_ACCEL;
				demandStrobe  = 1'b1;
				wdLoad = 1'b1;
				nxt_state = ST_ACCEL;
			end
			ST_ACCEL: if (p.demodActive) begin
				nxt_demandVal = DEMAND_ZERO;
				demandStrobe  = 1'b1;
				nxt_pulseCnt  = 7'h00;
				nxt_state = ST_COAST;
			end
			ST_COAST: if (cylRise) begin
				nxt_pulseCnt = pulseCnt_ff + 7'h01;
				if (pulseCnt_ff == COAST_LAST) begin
					nxt_demandVal = DEMAND_DECEL;
					demandStrobe  = 1'b1;
					nxt_decelCnt  = 16'h0000;
					nxt_state = ST_DECEL;
				end
			end
			ST_DECEL: begin
				nxt_decelCnt = decelCnt_ff + 16'h0001;
				if (decelCnt_ff == DECEL_LAST) begin
					nxt_demandVal = DEMAND_ZERO;
					demandStrobe  = 1'b1;
					nxt_cmd.homeTrackSeek = 1'b1;
					wdLoad = 1'b1;
					nxt_state = ST_HOME;
				end
			end
			ST_HOME: if (doneRise) begin
				nxt_calPhase = 2'h0;
				nxt_calTry   = 2'h0;
				nxt_cmd.calSeekGo = 1'b1;
				wdLoad = 1'b1;
				nxt_state = ST_CAL;
			end
			ST_CAL: if (p.calError || wdExp) begin
				if (calTry_ff == CAL_LAST) begin
					nxt_faultPend = 1'b1;
					wdLoad = 1'b1;
					nxt_state = ST_RETRACT;
				end else begin
					nxt_calTry   = calTry_ff + 2'h1;
					nxt_calPhase = 2'h0;
					nxt_cmd.calSeekGo = 1'b1;
					wdLoad = 1'b1;
				end
			end else if (doneRise) begin
				wdLoad = 1'b1;
				if (calPhase_ff == 2'h3) begin
					nxt_settled = 1'b1;
					nxt_avail   = 1'b1;
					nxt_posErr  = 1'b0;
					nxt_state = ST_READY;
				end else begin
					nxt_calPhase = calPhase_ff + 2'h1;
					nxt_cmd.calSeekGo = 1'b1;
				end
			end
			ST_READY: begin
				if (!p.onCylLimits) begin
					nxt_settled = 1'b0;
					nxt_posErr  = 1'b1;
				end
				if (!p.startCond || (pollExp && !speedOk)) begin
					nxt_settled = 1'b0;
					nxt_avail   = 1'b0;
					nxt_faultPend = 1'b0;
					wdLoad = 1'b1;
					nxt_state = ST_RETRACT;
				end
			end
			ST_RETRACT: if (!p.demodActive || wdExp) begin
				nxt_demandVal = DEMAND_ZERO;
				demandStrobe  = 1'b1;
				nxt_ctl.ampEnable    = 1'b0;
				nxt_ctl.actuatorLock = 1'b1;
				nxt_fault = faultPend_ff;
				nxt_ctl.spindleRun = faultPend_ff;
				nxt_state = faultPend_ff ? ST_FAULT : ST_IDLE;
			end else if (demand_ff != DEMAND_RETRACT) begin
				nxt_demandVal = DEMAND_RETRACT;
				demandStrobe  = 1'b1;
			end
			ST_FAULT: if (panelRise || hostClrOk) begin
				nxt_fault     = 1'b0;
				nxt_faultPend = 1'b0;
				nxt_posErr    = 1'b0;
				if (hostClrOk)
					nxt_hostClr = hostClr_ff + 3'h1;
				nxt_state = ST_SPIN;
			end
			ST_EPARK: if (!p.supplyLow) begin
				nxt_ctl.emergencyPark = 1'b0;
				nxt_ctl.spindleRun    = 1'b0;
				nxt_state = ST_IDLE;
			end
			default: nxt_state = ST_IDLE;
		endcase
		// load supervision: heads-loaded and on-track must each come in time
		if (wdExp && (state_ff inside {ST_ACCEL, ST_COAST, ST_DECEL, ST_HOME})) begin
			nxt_faultPend = 1'b1;
			wdLoad = 1'b1;
			nxt_state = ST_RETRACT;
		end
		if (p.supplyLow && state_ff != ST_EPARK) begin
			nxt_ctl.ampEnable     = 1'b0;
			nxt_ctl.emergencyPark = 1'b1;
			nxt_ctl.servoClear    = 1'b1;
			nxt_settled = 1'b0;
			nxt_avail   = 1'b0;
			nxt_state = ST_EPARK;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			state_ff     <= ST_IDLE;
			ctl_ff       <= '{spindleRun: 1'b0, ampEnable: 1'b0, emergencyPark: 1'b0,
			                  actuatorLock: 1'b1, servoClear: 1'b1};
			cmd_ff       <= '0;
			calPhase_ff  <= 2'h0;
			calTry_ff    <= 2'h0;
			pulseCnt_ff  <= 7'h00;
			decelCnt_ff  <= 16'h0000;
			hostClr_ff   <= 3'h0;
			faultPend_ff <= 1'b0;
			fault_ff     <= 1'b0;
			settled_ff   <= 1'b0;
			avail_ff     <= 1'b0;
			posErr_ff    <= 1'b0;
		end else begin
			state_ff     <= nxt_state;
			ctl_ff       <= nxt_ctl;
			cmd_ff       <= nxt_cmd;
			calPhase_ff  <= nxt_calPhase;
			calTry_ff    <= nxt_calTry;
			pulseCnt_ff  <= nxt_pulseCnt;
			decelCnt_ff  <= nxt_decelCnt;
			hostClr_ff   <= nxt_hostClr;
			faultPend_ff <= nxt_faultPend;
			fault_ff     <= nxt_fault;
			settled_ff   <= nxt_settled;
			avail_ff     <= nxt_avail;
			posErr_ff    <= nxt_posErr;
		end
	end

	// demand register: clear wins over a strobe so no force is commanded from the cycle after servoClear is set
	always_ff @(posedge core_clk) begin
		if (rst || ctl_ff.servoClear)
			demand_ff <= DEMAND_ZERO;
		else if (demandStrobe)
			demand_ff <= nxt_demandVal;
	end

	// calibration measurements during the continuous seeks
	always_ff @(posedge core_clk) begin
		if (rst) begin
			agc_ff   <= 8'h00;
			force_ff <= 16'h0000;
			tpt_ff   <= 16'h0000;
		end else if (contSeek && cylRise) begin
			agc_ff   <= p.peakLevel;
			force_ff <= tpt_ff;
			// the rise cycle already belongs to the new track
			tpt_ff   <= 16'h0001;
		end else if (contSeek && tpt_ff != 16'hffff)
			tpt_ff <= tpt_ff + 16'h0001;
	end

	assign ctl              = ctl_ff;
	assign cmd              = cmd_ff;
	assign calKind          = calPhase_ff;
	assign driveDemand      = demand_ff;
	assign agcLevel         = agc_ff;
	assign forceConst       = force_ff;
	// park with amplifier off: the inward channel stays up on its own bias
	assign outwardChanEn    = ctl_ff.ampEnable && !ctl_ff.emergencyPark;
	assign inwardChanEn     = ctl_ff.ampEnable || ctl_ff.emergencyPark;
	assign initialSeekFault = fault_ff;
	assign trackSettled     = settled_ff;
	assign seekComplete     = settled_ff || fault_ff;
	assign driveAvailable   = avail_ff;
endmodule // hls_sequencer

// ===== test/hls_checker.sv
/*
 port checker for the head load sequencer.
 assumes it is bound into hls_sequencer and sees only its ports.
*/
`timescale 1ns/1ps
module hls_checker
	import hls_pkg::*;
#(
	parameter int unsigned POLL_CNT = POLL_CYCLES
) (
	input wire logic                  core_clk,
	input wire logic                  rst,
	input wire hls_pkg::hls_pins_type pins,
	input wire hls_pkg::hls_ctl_type  ctl,
	input wire hls_pkg::hls_cmd_type  cmd,
	input wire logic [11:0]           driveDemand,
	input wire logic                  inwardChanEn,
	input wire logic                  outwardChanEn,
	input wire logic                  initialSeekFault,
	input wire logic                  trackSettled,
	input wire logic                  seekComplete,
	input wire logic                  driveAvailable
);
	logic [31:0] gap_ff;
	logic [7:0]  cyl_ff;
	logic        lastCyl_ff;
	// raw pin rises; the sequencer sees them later, but the coast ends well before the next one
	wire         cylRise = pins.cylPulse && !lastCyl_ff && driveDemand == DEMAND_ZERO && cyl_ff != 8'hff;

	always_ff @(posedge core_clk) begin
		if (rst) begin
			gap_ff     <= 32'h0;
			cyl_ff     <= 8'h0;
			lastCyl_ff <= 1'b0;
		end else begin
			lastCyl_ff <= pins.cylPulse;
			gap_ff     <= cmd.statusRequest ? 32'h1 : gap_ff + {31'h0, gap_ff != 32'h0};
			cyl_ff     <= driveDemand == DEMAND_ACCEL ? 8'h0 : cyl_ff + {7'h0, cylRise};
		end
	end

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);

	spin_start_a: assert property ($rose(ctl.spindleRun) |-> $past(pins.startCond, 3))
		else $error("spindle run without start conditions");
	poll_gap_a: assert property (cmd.statusRequest && gap_ff != 32'h0 |-> gap_ff >= POLL_CNT)
		else $error("status polls too close");
	load_enable_a: assert property (cmd.loadCmd |-> ctl.ampEnable && !ctl.actuatorLock && !ctl.servoClear)
		else $error("load command without amplifier enabled");
	coast_count_a: assert property ($rose(driveDemand == DEMAND_DECEL) |-> cyl_ff == COAST_PULSES)
		else $error("deceleration not after the coast count");
	ready_flags_a: assert property ($rose(driveAvailable) |-> trackSettled && seekComplete && !initialSeekFault)
		else $error("available without settled status");
	fault_park_a: assert property ($rose(initialSeekFault) |-> ctl.actuatorLock && !ctl.ampEnable && driveDemand == 12'h0)
		else $error("fault set with actuator not parked");
	park_gate_a: assert property (ctl.emergencyPark && !ctl.ampEnable |-> inwardChanEn && !outwardChanEn)
		else $error("wrong amplifier channel in park");
	supply_park_a: assert property ($rose(pins.supplyLow) |-> ##[1:4] (ctl.emergencyPark && !ctl.ampEnable))
		else $error("no emergency park on supply loss");
	clear_demand_a: assert property (ctl.servoClear [*2] |-> driveDemand == DEMAND_ZERO)
		else $error("demand not cleared by servo clear");
	normal_amp_a: assert property (trackSettled |-> ctl.ampEnable && !ctl.emergencyPark)
		else $error("settled without normal amplifier state");

	cover property ($rose(driveAvailable));
	cover property ($rose(initialSeekFault));
	cover property ($rose(ctl.emergencyPark));
endmodule // hls_checker

bind hls_sequencer hls_checker #(.POLL_CNT(POLL_CNT)) hls_checker_inst (.*);

// ===== test/hls_partner.sv
/*
 far side model: spindle processor and positioner processor.
 assumes the sequencer's outputs on core_clk; mute withholds seek reports.
*/
`timescale 1ns/1ps
module hls_partner
	import hls_pkg::*;
(
	input  wire logic                 core_clk,
	input  wire logic                 rst,
	input  wire logic                 mute,
	input  wire hls_pkg::hls_ctl_type ctl,
	input  wire hls_pkg::hls_cmd_type cmd,
	input  wire logic [11:0]          driveDemand,
	input  wire logic [1:0]           calKind,
	output logic [2:0]                spinStatus,
	output logic                      demodActive,
	output logic                      cylPulse,
	output logic                      seekDone,
	output logic                      onCylLimits
);
	logic [4:0] tick_ff;
	logic [2:0] phase_ff;
	logic [5:0] seek_ff;
	logic       coastDone_ff;
	// heads take 21 cycles to reach or leave the servo pattern
	wire        moving = (driveDemand == DEMAND_ACCEL && !demodActive) ||
		((driveDemand == DEMAND_RETRACT || ctl.emergencyPark) && demodActive);

	always @(posedge core_clk) begin
		if (rst) begin
			{tick_ff, phase_ff, seek_ff, coastDone_ff} <= '0;
			{spinStatus, demodActive, cylPulse, seekDone, onCylLimits} <= '0;
		end else begin
			spinStatus <= ctl.spindleRun ? SPIN_SPEED_OK : 3'h0;
			tick_ff <= moving ? tick_ff + 5'h1 : 5'h0;
			if (tick_ff == 5'd20) demodActive <= !demodActive;
			if (driveDemand == DEMAND_ACCEL) coastDone_ff <= 1'b0;
			if (driveDemand == DEMAND_DECEL) coastDone_ff <= 1'b1;
			// tracks also pass under the heads during the continuous calibration seeks
			if (demodActive && ((driveDemand == DEMAND_ZERO && !coastDone_ff) || (calKind[1] && seek_ff != 6'h0)))
				phase_ff <= phase_ff + 3'h1;
			cylPulse <= phase_ff[2];
			if (cmd.homeTrackSeek || cmd.calSeekGo) seek_ff <= mute ? 6'h0 : 6'h1;
			else if (seek_ff != 6'h0) seek_ff <= seek_ff + 6'h1;
			seekDone <= seek_ff >= 6'd30 && seek_ff < 6'd34;
			onCylLimits <= demodActive;
		end
	end
endmodule // hls_partner

// ===== test/hls_sequencer_tb_top.sv
/*
 testbench for the head load sequencer with a flag and status model.
 assumes hls_partner answers for spindle and positioner.
*/
`timescale 1ns/1ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin bad_count++; \
	$display("wrong value at %0t: got %h expected %h", $time, g, e); end end
`define WAITC(c, n) for (int k = 0; k < (n) && !(c); k++) @(posedge core_clk);
module hls_sequencer_tb_top;
	import hls_pkg::*;
	logic core_clk, rst, mute, startCond, supplyLow, panelClear;
	logic demodActive, cylPulse, seekDone, onCylLimits, expF, expS, expA, calErr;
	logic inwardChanEn, outwardChanEn, initialSeekFault, trackSettled, seekComplete, driveAvailable;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [1:0] calKind, s_axi_bresp, s_axi_rresp, rsp;
	logic [2:0] spinStatus;
	logic [3:0] s_axi_wstrb;
	logic [7:0] peakLevel, agcLevel, s_axi_awaddr, s_axi_araddr;
	logic [11:0] driveDemand;
	logic [15:0] forceConst;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd;
	hls_pins_type pins;
	hls_ctl_type ctl;
	hls_cmd_type cmd;
	int bad_count, n_checks, cycles, expClears;

	assign pins = '{startCond, spinStatus, demodActive, cylPulse, supplyLow, panelClear, seekDone, calErr, onCylLimits, peakLevel};
	hls_sequencer #(.POLL_CNT(50)) hls_sequencer_inst (.*);
	hls_partner hls_partner_inst (.*);

	initial core_clk = 1'b0;
	always #12.5 core_clk = ~core_clk;
	always @(posedge core_clk) begin
		cycles <= cycles + 1;
		if (cycles == 60000) begin
			bad_count++;
			report_and_stop();
		end
	end

	task automatic axw(input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge core_clk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		s_axi_bready <= 1'b0;
		rsp = s_axi_bresp;
	endtask

	task automatic axr(input logic [7:0] a);
		@(posedge core_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge core_clk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		s_axi_rready <= 1'b0;
		rd = s_axi_rdata;
		rsp = s_axi_rresp;
	endtask

	task automatic chkState();
		axr(ADDR_STATUS);
		`CHK(rd & 32'h9fb, {20'h0, 1'b1, 2'h0, 3'(expClears), 2'h0, expA, 1'b0, expS, expF})
		`CHK({initialSeekFault, trackSettled, driveAvailable}, {expF, expS, expA})
	endtask

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	initial begin
		void'($urandom(32'h886a5e90));
		{rst, mute, startCond, supplyLow, panelClear, calErr} = 6'b101000;
		// peak level held for the whole run so the sampled gain is known
		peakLevel = 8'($urandom);
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = {16'h0, 32'h0, 4'hf};
		{expF, expS, expA, expClears, cycles} = '0;
		repeat (2) @(posedge core_clk);
		rst <= 1'b0;
		repeat (120) @(posedge core_clk);
		`CHK({ctl.spindleRun, ctl.ampEnable, cmd.loadCmd}, 3'h0)
		axw(ADDR_TIMEOUT, 32'h2000);
		axr(ADDR_TIMEOUT);
		`CHK({rsp, rd}, {RESP_OKAY, 32'h2000})
		axw(ADDR_CTRL, 32'h2);
		`WAITC(driveAvailable === 1'b1, 20000)
		{expS, expA} = 2'b11;
		chkState();
		`CHK({calKind, ctl.ampEnable, ctl.emergencyPark}, 4'he)
		`CHK({agcLevel, forceConst}, {peakLevel, 16'h0008})
		$display("test load done");
		// supply loss, then a short watchdog so the next load times out in the coast
		supplyLow <= 1'b1;
		repeat (30) @(posedge core_clk);
		`CHK({ctl.emergencyPark, ctl.ampEnable, inwardChanEn, outwardChanEn}, 4'b1010)
		`CHK({trackSettled, driveAvailable, driveDemand}, 14'h0)
		{expS, expA} = 2'b00;
		axw(ADDR_TIMEOUT, 32'h100);
		supplyLow <= 1'b0;
		`WAITC(initialSeekFault === 1'b1, 5000)
		expF = 1'b1;
		chkState();
		$display("test park and load fault done");
		for (int i = 0; i < 6; i++) begin
			axw(ADDR_CTRL, 32'h3);
			if (i < HOST_CLR_MAX) expClears++;
			`WAITC(initialSeekFault === 1'b0, 40)
			`CHK(initialSeekFault, 1'(i >= HOST_CLR_MAX))
			`WAITC(initialSeekFault === 1'b1, 5000)
			chkState();
		end
		$display("test host clears done");
		axw(ADDR_TIMEOUT, 32'h2000);
		for (int j = 0; j < 3; j++) begin
			mute <= 1'(j == 0);
			calErr <= 1'(j == 1);
			panelClear <= 1'b1;
			`WAITC(initialSeekFault === 1'b0, 40)
			panelClear <= 1'b0;
			`CHK(initialSeekFault, 1'b0)
			`WAITC(initialSeekFault === 1'(j < 2) && driveAvailable === 1'(j == 2), 20000)
			{expF, expS, expA} = j < 2 ? 3'b100 : 3'b011;
			chkState();
			if (j == 1) `CHK(rd[10:9], 2'(CAL_ATTEMPTS - 1))
		end
		$display("test panel clears done");
		axr(8'h20);
		`CHK({rsp, rd}, {RESP_SLVERR, 32'h0})
		axw(8'h24, 32'h1);
		`CHK(rsp, RESP_SLVERR)
		$display("test unmapped done");
		report_and_stop();
	end
endmodule // hls_sequencer_tb_top
